// file: rtl/dtcu_top.sv
/*
 * Debug trigger unit: index register, per-trigger config and compare
 * words reached by CSR accesses, and the match logic that asks the core
 * to enter debug mode.
 * Assumes the core presents the final CSR write value (after any set or
 * clear) on csr_wdata with csr_we, and that all inputs share core_clk.
 */
`timescale 1ns/1ps
module dtcu_top #(
    parameter int trigger_count_param = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] csr_addr,
    input wire logic csr_we,
    input wire logic csr_re,
    input wire logic [31:0] csr_wdata,
    output logic [31:0] csr_rdata,
    output logic csr_rvalid,
    output logic csr_addr_hit,
    input wire logic debug_mode,
    input wire logic priv_machine,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic load_valid,
    input wire logic [31:0] load_addr,
    input wire logic store_valid,
    input wire logic [31:0] store_addr,
    input wire logic exc_valid,
    input wire logic [4:0] exc_code,
    output logic fetch_trig_hit,
    output logic lsu_trig_hit,
    output logic exc_trig_hit,
    output logic debug_entry_req
);

    localparam int IDX_W = (trigger_count_param > 1) ?
                           $clog2(trigger_count_param) : 1;
    localparam logic [31:0] COUNT_W32 = 32'(trigger_count_param);

    logic [IDX_W-1:0] sel_q;
    logic [31:0] csr_rdata_q;
    logic csr_rvalid_q;

    logic sel_wr;
    logic cfg_wr;
    logic cmp_wr;

    dtcu_pkg::dtcu_kind_t wr_kind;
    dtcu_pkg::dtcu_match_t wr_match;
    logic wr_m;
    logic wr_fetch;
    logic wr_store;
    logic wr_load;

    dtcu_pkg::dtcu_kind_t kind_q [trigger_count_param];
    dtcu_pkg::dtcu_match_t match_q [trigger_count_param];
    logic m_q [trigger_count_param];
    logic fetch_q [trigger_count_param];
    logic store_q [trigger_count_param];
    logic load_q [trigger_count_param];
    logic [31:0] cmp_q [trigger_count_param];
    logic [31:0] cfg_word [trigger_count_param];

    logic [trigger_count_param-1:0] fetch_hit_v;
    logic [trigger_count_param-1:0] lsu_hit_v;
    logic [trigger_count_param-1:0] exc_hit_v;

    logic [31:0] rd_mux;

    // Build the read view of a config word from its stored fields
    function automatic logic [31:0] pack_cfg(
        input dtcu_pkg::dtcu_kind_t k,
        input dtcu_pkg::dtcu_match_t mo,
        input logic m,
        input logic fe,
        input logic st,
        input logic ld);
        logic [31:0] w;
        logic [3:0] mcode;
        w = 32'h0000_0000;
        mcode = dtcu_pkg::MATCH_EQ;
        unique case (mo)
            dtcu_pkg::DTCU_M_GE: mcode = dtcu_pkg::MATCH_GE;
            dtcu_pkg::DTCU_M_LT: mcode = dtcu_pkg::MATCH_LT;
            default: mcode = dtcu_pkg::MATCH_EQ;
        endcase
        // Every view has the debug-only bit set
        w[dtcu_pkg::DBG_ONLY_BIT] = 1'b1;
        unique case (k)
            dtcu_pkg::DTCU_K_ADDR2,
            dtcu_pkg::DTCU_K_ADDR6: begin
                // Mask limit, fired, select, break_bit_a, size, chain, and the
                // supervisor/user enables are left at zero
                if (k == dtcu_pkg::DTCU_K_ADDR2) begin
                    w[dtcu_pkg::KIND_HI:dtcu_pkg::KIND_LO] =
                        dtcu_pkg::KIND_ADDR2;
                end else begin
                    w[dtcu_pkg::KIND_HI:dtcu_pkg::KIND_LO] =
                        dtcu_pkg::KIND_ADDR6;
                end
                w[dtcu_pkg::FIRE_LO+3:dtcu_pkg::FIRE_LO] =
                    dtcu_pkg::FIRE_ADDR;
                w[dtcu_pkg::MATCH_HI:dtcu_pkg::MATCH_LO] = mcode;
                w[dtcu_pkg::M_BIT_ADDR] = m;
                w[dtcu_pkg::FETCH_BIT] = fe;
                w[dtcu_pkg::STORE_BIT] = st;
                w[dtcu_pkg::LOAD_BIT] = ld;
            end
            dtcu_pkg::DTCU_K_EXC: begin
                w[dtcu_pkg::KIND_HI:dtcu_pkg::KIND_LO] =
                    dtcu_pkg::KIND_EXC;
                w[dtcu_pkg::M_BIT_EXC] = m;
                w[5:0] = dtcu_pkg::FIRE_EXC;
            end
            default: begin
                w[dtcu_pkg::KIND_HI:dtcu_pkg::KIND_LO] =
                    dtcu_pkg::KIND_OFF;
            end
        endcase
        return w;
    endfunction

    // Write strobes; data registers only listen in debug mode
    assign sel_wr = csr_we & (csr_addr == dtcu_pkg::ADDR_TSEL);
    assign cfg_wr = csr_we & debug_mode &
                    (csr_addr == dtcu_pkg::ADDR_TCFG);
    assign cmp_wr = csr_we & debug_mode &
                    (csr_addr == dtcu_pkg::ADDR_TCMP);

    assign csr_addr_hit = (csr_addr == dtcu_pkg::ADDR_TSEL) ||
                          (csr_addr == dtcu_pkg::ADDR_TCFG) ||
                          (csr_addr == dtcu_pkg::ADDR_TCMP);

    // Legalise a config write by the kind it asks for
    always_comb begin
        wr_kind = dtcu_pkg::DTCU_K_OFF;
        wr_match = dtcu_pkg::DTCU_M_EQ;
        wr_m = 1'b0;
        wr_fetch = 1'b0;
        wr_store = 1'b0;
        wr_load = 1'b0;
        if (csr_wdata == 32'h0000_0000) begin
            wr_kind = dtcu_pkg::DTCU_K_OFF;
        end else begin
            // Unsupported kind codes fall back to the disabled encoding
            unique case (csr_wdata[dtcu_pkg::KIND_HI:dtcu_pkg::KIND_LO])
                dtcu_pkg::KIND_ADDR2: wr_kind = dtcu_pkg::DTCU_K_ADDR2;
                dtcu_pkg::KIND_EXC: wr_kind = dtcu_pkg::DTCU_K_EXC;
                dtcu_pkg::KIND_ADDR6: wr_kind = dtcu_pkg::DTCU_K_ADDR6;
                default: wr_kind = dtcu_pkg::DTCU_K_OFF;
            endcase
        end
        unique case (wr_kind)
            dtcu_pkg::DTCU_K_ADDR2,
            dtcu_pkg::DTCU_K_ADDR6: begin
                // Illegal compare kinds collapse to equality
                unique case (csr_wdata[dtcu_pkg::MATCH_HI:dtcu_pkg::MATCH_LO])
                    dtcu_pkg::MATCH_GE: wr_match = dtcu_pkg::DTCU_M_GE;
                    dtcu_pkg::MATCH_LT: wr_match = dtcu_pkg::DTCU_M_LT;
                    default: wr_match = dtcu_pkg::DTCU_M_EQ;
                endcase
                wr_m = csr_wdata[dtcu_pkg::M_BIT_ADDR];
                wr_fetch = csr_wdata[dtcu_pkg::FETCH_BIT];
                wr_store = csr_wdata[dtcu_pkg::STORE_BIT];
                wr_load = csr_wdata[dtcu_pkg::LOAD_BIT];
            end
            dtcu_pkg::DTCU_K_EXC: begin
                wr_m = csr_wdata[dtcu_pkg::M_BIT_EXC];
            end
            default: begin
                wr_m = 1'b0;
            end
        endcase
    end

    // Index register: out-of-range writes keep the old selection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q <= dtcu_pkg::RST_TSEL[IDX_W-1:0];
        end else if (sel_wr && (csr_wdata < COUNT_W32)) begin
            sel_q <= csr_wdata[IDX_W-1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < trigger_count_param; g++) begin : g_trig
            logic here;

            assign here = (sel_q == IDX_W'(g));

            // Config fields of this trigger
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    kind_q[g] <= dtcu_pkg::DTCU_K_ADDR2;
                    match_q[g] <= dtcu_pkg::DTCU_M_EQ;
                    m_q[g] <= dtcu_pkg::RST_TCFG[dtcu_pkg::M_BIT_ADDR];
                    fetch_q[g] <= dtcu_pkg::RST_TCFG[dtcu_pkg::FETCH_BIT];
                    store_q[g] <= dtcu_pkg::RST_TCFG[dtcu_pkg::STORE_BIT];
                    load_q[g] <= dtcu_pkg::RST_TCFG[dtcu_pkg::LOAD_BIT];
                end else if (cfg_wr && here) begin
                    kind_q[g] <= wr_kind;
                    match_q[g] <= wr_match;
                    m_q[g] <= wr_m;
                    fetch_q[g] <= wr_fetch;
                    store_q[g] <= wr_store;
                    load_q[g] <= wr_load;
                end
            end

            // Compare word; exception kind keeps only selectable codes
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    cmp_q[g] <= dtcu_pkg::RST_TCMP;
                end else if (cmp_wr && here) begin
                    if (kind_q[g] == dtcu_pkg::DTCU_K_EXC) begin
                        cmp_q[g] <= csr_wdata &
                                    dtcu_pkg::EXC_SEL_MASK;
                    end else begin
                        cmp_q[g] <= csr_wdata;
                    end
                end
            end

            assign cfg_word[g] = pack_cfg(kind_q[g], match_q[g], m_q[g],
                                          fetch_q[g], store_q[g],
                                          load_q[g]);

            dtcu_match u_match (
                .kind(kind_q[g]),
                .match_op(match_q[g]),
                .m_en(m_q[g]),
                .fetch_en(fetch_q[g]),
                .store_en(store_q[g]),
                .load_en(load_q[g]),
                .cmp_value(cmp_q[g]),
                .priv_machine(priv_machine),
                .debug_mode(debug_mode),
                .fetch_valid(fetch_valid),
                .fetch_addr(fetch_addr),
                .load_valid(load_valid),
                .load_addr(load_addr),
                .store_valid(store_valid),
                .store_addr(store_addr),
                .exc_valid(exc_valid),
                .exc_code(exc_code),
                .fetch_hit(fetch_hit_v[g]),
                .lsu_hit(lsu_hit_v[g]),
                .exc_hit(exc_hit_v[g])
            );
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (csr_addr)
            dtcu_pkg::ADDR_TSEL: rd_mux = 32'(sel_q);
            dtcu_pkg::ADDR_TCFG: rd_mux = cfg_word[sel_q];
            dtcu_pkg::ADDR_TCMP: rd_mux = cmp_q[sel_q];
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is registered so it is stable for a full cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_rdata_q <= 32'h0000_0000;
        end else if (csr_re) begin
            csr_rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csr_rvalid_q <= 1'b0;
        end else begin
            csr_rvalid_q <= csr_re;
        end
    end

    assign csr_rdata = csr_rdata_q;
    assign csr_rvalid = csr_rvalid_q;

    // Hits are combinational so the core can stop before execution
    assign fetch_trig_hit = |fetch_hit_v;
    assign lsu_trig_hit = |lsu_hit_v;
    assign exc_trig_hit = |exc_hit_v;
    assign debug_entry_req = fetch_trig_hit | lsu_trig_hit |
                             exc_trig_hit;

endmodule

// file: rtl/dtcu_pkg.sv
/*
 * Constants, field positions and types of the debug trigger unit.
 * Assumes a 32-bit CSR datapath and 12-bit CSR addresses from the core.
 */
package dtcu_pkg;

    localparam logic [11:0] ADDR_TSEL = 12'h7A0;
    localparam logic [11:0] ADDR_TCFG = 12'h7A1;
    localparam logic [11:0] ADDR_TCMP = 12'h7A2;

    localparam logic [31:0] RST_TSEL = 32'h0000_0000;
    localparam logic [31:0] RST_TCFG = 32'h2800_1000;
    localparam logic [31:0] RST_TCMP = 32'h0000_0000;

    localparam int KIND_HI = 31;
    localparam int KIND_LO = 28;
    localparam int DBG_ONLY_BIT = 27;
    localparam int FIRE_LO = 12;
    localparam int MATCH_HI = 10;
    localparam int MATCH_LO = 7;
    localparam int M_BIT_ADDR = 6;
    localparam int M_BIT_EXC = 9;
    localparam int FETCH_BIT = 2;
    localparam int STORE_BIT = 1;
    localparam int LOAD_BIT = 0;

    localparam logic [3:0] KIND_ADDR2 = 4'h2;
    localparam logic [3:0] KIND_EXC = 4'h5;
    localparam logic [3:0] KIND_ADDR6 = 4'h6;
    localparam logic [3:0] KIND_OFF = 4'hF;

    localparam logic [3:0] MATCH_EQ = 4'h0;
    localparam logic [3:0] MATCH_GE = 4'h2;
    localparam logic [3:0] MATCH_LT = 4'h3;

    localparam logic [3:0] FIRE_ADDR = 4'h1;
    localparam logic [5:0] FIRE_EXC = 6'h01;

    // Exception codes that can be selected in the compare word
    localparam logic [31:0] EXC_SEL_MASK = 32'h0100_08AE;

    typedef enum logic [1:0] {
        DTCU_K_ADDR2,
        DTCU_K_EXC,
        DTCU_K_ADDR6,
        DTCU_K_OFF
    } dtcu_kind_t;

    typedef enum logic [1:0] {
        DTCU_M_EQ,
        DTCU_M_GE,
        DTCU_M_LT
    } dtcu_match_t;

endpackage

// file: rtl/dtcu_match.sv
/*
 * Compare logic of one trigger.
 * Assumes request valids and addresses come from the core on the same clock.
 */
`timescale 1ns/1ps
module dtcu_match (
    input wire dtcu_pkg::dtcu_kind_t kind,
    input wire dtcu_pkg::dtcu_match_t match_op,
    input wire logic m_en,
    input wire logic fetch_en,
    input wire logic store_en,
    input wire logic load_en,
    input wire logic [31:0] cmp_value,
    input wire logic priv_machine,
    input wire logic debug_mode,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic load_valid,
    input wire logic [31:0] load_addr,
    input wire logic store_valid,
    input wire logic [31:0] store_addr,
    input wire logic exc_valid,
    input wire logic [4:0] exc_code,
    output logic fetch_hit,
    output logic lsu_hit,
    output logic exc_hit
);

    logic armed;
    logic is_addr;

    // Address compare only; data values never take part
    function automatic logic addr_cmp(input logic [31:0] a,
                                      input logic [31:0] v,
                                      input dtcu_pkg::dtcu_match_t op);
        logic r;
        r = 1'b0;
        unique case (op)
            dtcu_pkg::DTCU_M_EQ: r = (a == v);
            dtcu_pkg::DTCU_M_GE: r = (a >= v);
            dtcu_pkg::DTCU_M_LT: r = (a < v);
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Triggers stay quiet while already in debug mode
    assign armed = m_en & priv_machine & ~debug_mode;
    assign is_addr = (kind == dtcu_pkg::DTCU_K_ADDR2) ||
                     (kind == dtcu_pkg::DTCU_K_ADDR6);

    assign fetch_hit = armed & is_addr & fetch_en & fetch_valid &
        addr_cmp(fetch_addr, cmp_value, match_op);
    assign lsu_hit = armed & is_addr &
        ((store_en & store_valid &
          addr_cmp(store_addr, cmp_value, match_op)) |
         (load_en & load_valid &
          addr_cmp(load_addr, cmp_value, match_op)));
    assign exc_hit = armed & (kind == dtcu_pkg::DTCU_K_EXC) & exc_valid &
        cmp_value[exc_code];

endmodule

// file: test/dtcu_monitor.sv
/*
 * Port checker for the debug trigger unit top.
 * Assumes it is bound to dtcu_top and sees only its ports.
 */
`timescale 1ns/1ps
module dtcu_monitor #(
    parameter int trigger_count_param = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [11:0] csr_addr,
    input wire logic csr_we,
    input wire logic csr_re,
    input wire logic [31:0] csr_wdata,
    input wire logic [31:0] csr_rdata,
    input wire logic csr_rvalid,
    input wire logic csr_addr_hit,
    input wire logic debug_mode,
    input wire logic priv_machine,
    input wire logic fetch_valid,
    input wire logic load_valid,
    input wire logic store_valid,
    input wire logic exc_valid,
    input wire logic fetch_trig_hit,
    input wire logic lsu_trig_hit,
    input wire logic exc_trig_hit,
    input wire logic debug_entry_req
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (csr_re |=> csr_rvalid)
        else $error("read got no answer");
    a_no_stray_answer: assert property (!csr_re |=> !csr_rvalid)
        else $error("answer without read");
    a_rdata_holds: assert property (!csr_rvalid |-> $stable(csr_rdata))
        else $error("read data moved without answer");
    a_unmapped_zero: assert property
        (csr_re && !csr_addr_hit |=> csr_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_addr_decode: assert property
        (csr_addr_hit == (csr_addr inside {12'h7A0, 12'h7A1, 12'h7A2}))
        else $error("address decode wrong");
    a_entry_or: assert property
        (debug_entry_req == (fetch_trig_hit | lsu_trig_hit | exc_trig_hit))
        else $error("entry request not the hit union");
    a_quiet_in_debug: assert property (debug_mode |-> !debug_entry_req)
        else $error("hit while in debug mode");
    a_machine_only: assert property (!priv_machine |-> !debug_entry_req)
        else $error("hit outside machine mode");
    a_fetch_cause: assert property (fetch_trig_hit |-> fetch_valid)
        else $error("fetch hit without fetch");
    a_lsu_cause: assert property
        (lsu_trig_hit |-> load_valid || store_valid)
        else $error("data hit without access");
    a_exc_cause: assert property (exc_trig_hit |-> exc_valid)
        else $error("exception hit without exception");

    c_fetch_hit: cover property (fetch_trig_hit);
    c_lsu_hit: cover property (lsu_trig_hit);
    c_exc_hit: cover property (exc_trig_hit);
endmodule

bind dtcu_top dtcu_monitor #(.trigger_count_param(trigger_count_param)) u_mon (
    .core_clk(core_clk), .rst_n(rst_n), .csr_addr(csr_addr),
    .csr_we(csr_we), .csr_re(csr_re), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .csr_rvalid(csr_rvalid),
    .csr_addr_hit(csr_addr_hit), .debug_mode(debug_mode),
    .priv_machine(priv_machine), .fetch_valid(fetch_valid),
    .load_valid(load_valid), .store_valid(store_valid),
    .exc_valid(exc_valid), .fetch_trig_hit(fetch_trig_hit),
    .lsu_trig_hit(lsu_trig_hit), .exc_trig_hit(exc_trig_hit),
    .debug_entry_req(debug_entry_req)
);

// file: test/dtcu_core_model.sv
/*
 * Core pipeline model: presents fetch, load, store and exception events.
 * Assumes one bench process calls its tasks, on core_clk.
 */
`timescale 1ns/1ps
module dtcu_core_model (
    input wire logic core_clk,
    output logic fetch_valid,
    output logic [31:0] fetch_addr,
    output logic load_valid,
    output logic [31:0] load_addr,
    output logic store_valid,
    output logic [31:0] store_addr,
    output logic exc_valid,
    output logic [4:0] exc_code
);
    initial begin
        fetch_valid = 1'b0;
        load_valid = 1'b0;
        store_valid = 1'b0;
        exc_valid = 1'b0;
        fetch_addr = 32'hA5A5_5A5A;
        load_addr = 32'h5A5A_A5A5;
        store_addr = 32'hA5A5_5A5A;
        exc_code = 5'h1F;
    end

    // One event per call: 0 fetch, 1 load, 2 store, 3 exception
    task automatic issue(input logic [1:0] which, input logic [31:0] a);
        @(posedge core_clk);
        fetch_valid <= (which == 2'h0);
        load_valid <= (which == 2'h1);
        store_valid <= (which == 2'h2);
        exc_valid <= (which == 2'h3);
        fetch_addr <= a;
        load_addr <= a;
        store_addr <= a;
        exc_code <= a[4:0];
    endtask

    // Idle buses show garbage, so a stale address cannot fake a match
    task automatic quiet();
        @(posedge core_clk);
        fetch_valid <= 1'b0;
        load_valid <= 1'b0;
        store_valid <= 1'b0;
        exc_valid <= 1'b0;
        fetch_addr <= ~fetch_addr;
        load_addr <= ~load_addr;
        store_addr <= ~store_addr;
        exc_code <= ~exc_code;
    endtask
endmodule

// file: test/dtcu_tb_top.sv
/*
 * Self-checking bench for the debug trigger unit with two triggers.
 * Assumes dtcu_top, dtcu_core_model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module dtcu_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] csr_addr = 12'h000;
    logic csr_we = 1'b0;
    logic csr_re = 1'b0;
    logic [31:0] csr_wdata = 32'h0;
    logic debug_mode = 1'b0;
    logic priv_machine = 1'b0;
    logic [31:0] csr_rdata;
    logic csr_rvalid, csr_addr_hit, fetch_valid, load_valid, store_valid;
    logic exc_valid, fetch_trig_hit, lsu_trig_hit, exc_trig_hit, entry;
    logic [31:0] fetch_addr, load_addr, store_addr;
    logic [4:0] exc_code;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    always #2.5 core_clk = ~core_clk;

    dtcu_core_model u_dtcu_core_model (.core_clk(core_clk),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .load_valid(load_valid), .load_addr(load_addr),
        .store_valid(store_valid), .store_addr(store_addr),
        .exc_valid(exc_valid), .exc_code(exc_code));

    dtcu_top #(.trigger_count_param(2)) u_dtcu_top (.core_clk(core_clk),
        .rst_n(rst_n), .csr_addr(csr_addr), .csr_we(csr_we),
        .csr_re(csr_re), .csr_wdata(csr_wdata), .csr_rdata(csr_rdata),
        .csr_rvalid(csr_rvalid), .csr_addr_hit(csr_addr_hit),
        .debug_mode(debug_mode), .priv_machine(priv_machine),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .load_valid(load_valid), .load_addr(load_addr),
        .store_valid(store_valid), .store_addr(store_addr),
        .exc_valid(exc_valid), .exc_code(exc_code),
        .fetch_trig_hit(fetch_trig_hit), .lsu_trig_hit(lsu_trig_hit),
        .exc_trig_hit(exc_trig_hit), .debug_entry_req(entry));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t word %h expected %h", $time, got, exp);
        end
    endtask

    // Hits as fetch, data, exception; entry must be their union
    task automatic chk_hits(input logic [2:0] exp);
        check_count++;
        if ({fetch_trig_hit, lsu_trig_hit, exc_trig_hit, entry}
            !== {exp, |exp}) begin
            fail_count++;
            $display("BAD t=%0t hits wrong, expected %b", $time, exp);
        end
    endtask

    task automatic csr_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        csr_we <= 1'b1;
        csr_addr <= a;
        csr_wdata <= d;
        @(posedge core_clk);
        csr_we <= 1'b0;
        csr_wdata <= ~d;
    endtask

    task automatic csr_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        csr_re <= 1'b1;
        csr_addr <= a;
        @(posedge core_clk);
        csr_re <= 1'b0;
        #1;
        chk32({31'h0, csr_rvalid}, 32'h1);
        chk32(csr_rdata, exp);
    endtask

    task automatic mode(input logic d, input logic p);
        @(posedge core_clk);
        debug_mode <= d;
        priv_machine <= p;
    endtask

    task automatic cfg_case(input logic [31:0] w, input logic [31:0] e);
        csr_wr(12'h7A1, w);
        csr_rd(12'h7A1, e);
    endtask

    task automatic run_case(input logic [31:0] cfg, input logic [31:0] cmp,
        input logic [1:0] which, input logic [31:0] a, input logic p,
        input logic [2:0] exp);
        mode(1'b1, p);
        csr_wr(12'h7A1, cfg);
        csr_wr(12'h7A2, cmp);
        mode(1'b0, p);
        u_dtcu_core_model.issue(which, a);
        #1;
        chk_hits(exp);
        u_dtcu_core_model.quiet();
        mode(1'b1, p);
        u_dtcu_core_model.issue(which, a);
        #1;
        chk_hits(3'h0);
        u_dtcu_core_model.quiet();
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        csr_rd(12'h7A0, 32'h0000_0000);
        csr_rd(12'h7A1, 32'h2800_1000);
        csr_rd(12'h7A2, 32'h0000_0000);
        csr_wr(12'h7A1, 32'h2000_0047);
        csr_wr(12'h7A2, 32'h0000_1234);
        csr_rd(12'h7A1, 32'h2800_1000);
        csr_rd(12'h7A2, 32'h0000_0000);
        mode(1'b1, 1'b1);
        cfg_case(32'h0000_0000, 32'hF800_0000);
        cfg_case(32'h7000_0000, 32'hF800_0000);
        cfg_case(32'h8ABC_0000, 32'hF800_0000);
        cfg_case(32'hF000_1234, 32'hF800_0000);
        cfg_case(32'h2FFF_FFFF, 32'h2800_1047);
        cfg_case(32'h2000_0140, 32'h2800_1140);
        cfg_case(32'h2000_01C0, 32'h2800_11C0);
        cfg_case(32'h2000_0080, 32'h2800_1000);
        cfg_case(32'h5FFF_FFFF, 32'h5800_0201);
        cfg_case(32'h6FFF_FFFF, 32'h6800_1047);
        csr_wr(12'h7A1, 32'h5000_0200);
        csr_wr(12'h7A2, 32'hFFFF_FFFF);
        csr_rd(12'h7A2, 32'h0100_08AE);
        csr_wr(12'h7A1, 32'h2000_0000);
        csr_wr(12'h7A2, 32'hFFFF_FFFF);
        csr_rd(12'h7A2, 32'hFFFF_FFFF);
        csr_wr(12'h7A0, 32'h0000_0001);
        csr_rd(12'h7A0, 32'h0000_0001);
        csr_rd(12'h7A1, 32'h2800_1000);
        csr_wr(12'h7A1, 32'h0000_0000);
        csr_rd(12'h7A1, 32'hF800_0000);
        csr_wr(12'h7A0, 32'h0000_0002);
        csr_rd(12'h7A0, 32'h0000_0001);
        csr_wr(12'h7A0, 32'h0000_0000);
        csr_rd(12'h7A1, 32'h2800_1000);
        csr_wr(12'h7A3, 32'hFFFF_FFFF);
        csr_rd(12'h7A3, 32'h0000_0000);
        run_case(32'h2000_0044, 32'h1000, 2'h0, 32'h1000, 1'b1, 3'h4);
        run_case(32'h2000_0044, 32'h1000, 2'h0, 32'h1004, 1'b1, 3'h0);
        run_case(32'h2000_0044, 32'h1000, 2'h1, 32'h1000, 1'b1, 3'h0);
        run_case(32'h2000_0041, 32'h1000, 2'h1, 32'h1000, 1'b1, 3'h2);
        run_case(32'h2000_0042, 32'h1000, 2'h2, 32'h1000, 1'b1, 3'h2);
        run_case(32'h2000_0042, 32'h1000, 2'h1, 32'h1000, 1'b1, 3'h0);
        run_case(32'h2000_0144, 32'h1000, 2'h0, 32'h1000, 1'b1, 3'h4);
        run_case(32'h2000_0144, 32'h1000, 2'h0, 32'h0FFC, 1'b1, 3'h0);
        run_case(32'h2000_01C4, 32'h1000, 2'h0, 32'h0FFC, 1'b1, 3'h4);
        run_case(32'h2000_01C4, 32'h1000, 2'h0, 32'h1000, 1'b1, 3'h0);
        run_case(32'h2000_0004, 32'h1000, 2'h0, 32'h1000, 1'b1, 3'h0);
        run_case(32'h2000_0044, 32'h1000, 2'h0, 32'h1000, 1'b0, 3'h0);
        run_case(32'h5000_0200, '1, 2'h3, 32'h2, 1'b1, 3'h1);
        run_case(32'h5000_0200, '1, 2'h3, 32'h0, 1'b1, 3'h0);
        run_case(32'h5000_0000, '1, 2'h3, 32'h2, 1'b1, 3'h0);
        run_case(32'h0000_0000, 32'h1000, 2'h0, 32'h1000, 1'b1, 3'h0);
        run_case(32'h6000_0044, 32'h1000, 2'h0, 32'h1000, 1'b1, 3'h4);
        complete_run();
    end
endmodule
